// [bcc_consts.vh]
/*
 Register offsets, field positions, reset values and timing counts for the
 buck converter control block. Assumes a 25 MHz system clock.
*/
`ifndef BCC_CONSTS_VH
`define BCC_CONSTS_VH
`define BCC_ADDR_W 16
`define BCC_OFF_A_DVS 16'h405a
`define BCC_OFF_B_CTL1 16'h405b
`define BCC_OFF_B_CTL2 16'h405c
`define BCC_OFF_B_ON 16'h405d
`define BCC_OFF_B_SLP 16'h405e
`define BCC_OFF_B_DVS 16'h405f
`define BCC_OFF_C_CTL1 16'h4060
`define BCC_OFF_STATUS 16'h4070
`define BCC_OFF_KEY 16'h4071
`define BCC_KEY_VALUE 16'h9716
`define BCC_MASK_DVS 16'h187f
`define BCC_MASK_CTL1 16'hd3b3
`define BCC_MASK_CTL2 16'hdf71
`define BCC_MASK_ON 16'he37f
`define BCC_MASK_SLP 16'he37f
`define BCC_MASK_C1 16'h10bf
`define BCC_RST_DVS 16'h0000
`define BCC_RST_CTL1 16'h9000
`define BCC_RST_CTL2 16'h0300
`define BCC_RST_ON 16'h0100
`define BCC_RST_SLP 16'h0300
`define BCC_RST_C1 16'h0014
`define BCC_CLK_MHZ 25
`define BCC_STEP_US 8
`define BCC_STEP_CYC (`BCC_STEP_US * `BCC_CLK_MHZ)
`define BCC_SS_BASE_US 32
`define BCC_SS_BASE_CYC (`BCC_SS_BASE_US * `BCC_CLK_MHZ)
`define BCC_C_SS_US 512
`define BCC_C_SS_CYC (`BCC_C_SS_US * `BCC_CLK_MHZ)
`define BCC_B_SS_STEPS 4'h8
`define BCC_C_SS_STEPS 4'h3
`define BCC_VMIN_CODE 7'h08
`define BCC_VMAX_CODE 7'h68
`define BCC_MODE_FCCM 2'h0
`define BCC_MODE_AUTO 2'h1
`define BCC_MODE_LDO 2'h2
`define BCC_MODE_HYST 2'h3
`endif

// [bcc_host.sv]
/*
 Host model: register bus master for the bcc_top register port.
 Assumes its task is called just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bcc_host
(
	input wire logic sys_clk,
	output var logic [15:0] reg_addr,
	output var logic [15:0] reg_wdata,
	output var logic reg_write,
	output var logic reg_read
);
	// Bus idle at time zero.
	initial
	begin
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	// One strobe cycle, then an idle edge so calls never collide.
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= w;
		reg_read <= !w;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		reg_read <= 1'b0;
		reg_wdata <= ~d;
		@(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// [bcc_monitor.sv]
/*
 Checker on the bcc_top ports: read port timing, undervolt events, limits.
 Assumes it is bound to bcc_top from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.vh"
module bcc_monitor
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic buck_b_undervolt,
	input wire logic buck_b_undervolt_irq,
	input wire logic system_reset_req,
	input wire logic [3:0] buck_b_current_step,
	input wire logic [6:0] buck_b_voltage
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// An undervolt rise, and the single-cycle event that answers it.
	sequence s_rise; !buck_b_undervolt ##1 buck_b_undervolt; endsequence
	sequence s_pulse; buck_b_undervolt_irq ##1 !buck_b_undervolt_irq; endsequence
	property p_irq; s_rise |=> s_pulse; endproperty
	a_irq: assert property (p_irq) else $error("event missing");
	property p_cause; buck_b_undervolt_irq |-> $past(buck_b_undervolt)
		&& !$past(buck_b_undervolt, 2); endproperty
	a_cause: assert property (p_cause) else $error("stray event");
	property p_sys; system_reset_req |=> !system_reset_req; endproperty
	a_sys: assert property (p_sys) else $error("reset request long");
	property p_step; buck_b_current_step <= `BCC_B_SS_STEPS; endproperty
	a_step: assert property (p_step) else $error("step over range");
	// Soft start climbs one step at a time or drops back to zero.
	property p_inc; $changed(buck_b_current_step) |->
		buck_b_current_step == $past(buck_b_current_step) + 4'h1
		|| buck_b_current_step == 4'h0; endproperty
	a_inc: assert property (p_inc) else $error("step jump");
	property p_vmax; buck_b_voltage <= `BCC_VMAX_CODE; endproperty
	a_vmax: assert property (p_vmax) else $error("voltage high");
	property p_idle; !$past(reg_read) |-> reg_rdata == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("read data idle");
	property p_unmap; reg_read && reg_addr == 16'h4080
		|=> reg_rdata == 16'h0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped data");
endmodule
`default_nettype wire

// [bcc_ramp.v]
/*
 Output voltage code slewer: moves one code step per paced interval, or jumps straight to the target at rate 3.
 Assumes the target code is steady or changes only by register writes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.vh"
module bcc_ramp
(
	input wire sys_clk,
	input wire sys_rst,
	input wire [1:0] rate,
	input wire [6:0] target,
	output reg [6:0] level_reg
);
reg [12:0] tick_reg;
reg [12:0] tick_next;
reg [6:0] level_next;
reg [12:0] limit;
// Base step length, cut to the tick counter width on purpose.
wire [31:0] step_wide = `BCC_STEP_CYC;
// Pick the step interval from the rate code: four, two or one base step.
always @*
begin
	case (rate)
	2'h0: limit = {step_wide[10:0], 2'b00};
	2'h1: limit = {step_wide[11:0], 1'b0};
	default: limit = step_wide[12:0];
	endcase
end
// Step the level towards the target, or jump when rate is immediate.
always @*
begin
	tick_next = tick_reg + 13'h0001;
	level_next = level_reg;
	if (rate == 2'h3)
	begin
		level_next = target; // RULE4
		tick_next = 13'h0000;
	end
	else if (level_reg == target)
		tick_next = 13'h0000;
	else if (tick_next >= limit)
	begin
		tick_next = 13'h0000;
		if (level_reg < target)
			level_next = level_reg + 7'h01; // RULE4
		else
			level_next = level_reg - 7'h01;
	end
end
// State update.
always @(posedge sys_clk)
begin
	if (sys_rst)
	begin
		tick_reg <= 13'h0000;
		level_reg <= 7'h00;
	end
	else
	begin
		tick_reg <= tick_next;
		level_reg <= level_next;
	end
end
endmodule
`default_nettype wire

// [bcc_top.v]
/*
 Buck converter control registers and control logic for the second buck,
 plus the first buck scaling register and the third buck first control.
 Assumes synchronous inputs, a plain register port and a sequencer that
 supplies the current power-up and sleep timeslot numbers.
*/
// Summary of operation
// RULE1 - Scaling source: off, on, or follow hardware scaling input one or two.
// RULE2 - Voltage codes step 12.5 mV; low codes clamp 0.6 V, high 1.8 V.
// RULE3 - Software keeps voltage codes at or below 48h when switching 4 MHz.
// RULE4 - Ramp rate paces one code per 32, 16, 8 us, or immediate.
// RULE5 - Clock phase bit: second buck resets inverted, third buck normal.
// RULE6 - Frequency code 01 is 2 MHz, 11 is 4 MHz, others reserved.
// RULE7 - Output float bit: discharge output when disabled unless set; the third buck discharges whenever it is unset, enabled or not.
// RULE8 - Second buck soft start: eight steps of 32 to 256 us.
// RULE9 - Undervoltage action: ignore, shut converter, or system reset.
// RULE10 - Undervoltage always raises the interrupt event.
// RULE11 - Hardware control source: none, input one, two, or either.
// RULE12 - Under hardware control, bit 10 picks active or sleep voltage.
// RULE13 - Hardware control mode sets converter state; default hysteretic.
// RULE14 - High current detection enable with threshold 125 to 1000 mA.
// RULE15 - Power-on slot: never, timeslot 1 to 5, or hardware enable.
// RULE16 - Active mode encoding of four modes, resetting to auto.
// RULE17 - Active voltage split 5+2 bits; upper bits loadable from OTP.
// RULE18 - Sleep slot: transition in slot 5, 3, 1 or disable in 5..1.
// RULE19 - With hardware enable, disable codes choose sleep entry slot.
// RULE20 - Sleep mode and voltage share active encodings; mode hysteretic.
// RULE21 - Third buck soft start: three steps of 512 us, 4 ms, 32 ms.
// RULE22 - Third buck hysteretic current limit writable only when unlocked.
// RULE23 - Locked writes leave the protected field unchanged; reads work.
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.vh"
module bcc_top
(
	input wire sys_clk,
	input wire sys_rst,
	input wire [15:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [15:0] reg_rdata,
	input wire hw_scaling_input_one,
	input wire hw_scaling_input_two,
	input wire hwctl_one,
	input wire hwctl_two,
	input wire hw_enable_one,
	input wire hw_enable_two,
	input wire [2:0] power_on_timeslot,
	input wire [2:0] sleep_timeslot,
	input wire sleep_request,
	input wire buck_b_undervolt,
	input wire otp_load,
	input wire [4:0] otp_active_voltage,
	output reg buck_b_enable,
	output reg [1:0] buck_b_mode,
	output reg [6:0] buck_b_voltage,
	output reg buck_b_clk_invert,
	output reg [1:0] buck_b_freq,
	output reg buck_b_discharge,
	output reg [3:0] buck_b_current_step,
	output reg buck_b_hc_enable,
	output reg [2:0] buck_b_hc_threshold,
	output reg buck_b_undervolt_irq,
	output reg system_reset_req,
	output reg buck_a_scaling_active,
	output reg [1:0] buck_c_current_limit,
	output reg buck_c_discharge,
	output reg buck_c_clk_invert
);
reg [15:0] a_dvs_reg;
reg [15:0] b_ctl1_reg;
reg [15:0] b_ctl2_reg;
reg [15:0] b_on_reg;
reg [15:0] b_slp_reg;
reg [15:0] b_dvs_reg;
reg [15:0] c_ctl1_reg;
reg unlock_reg;
reg b_trip_reg;
reg b_on_reg_state;
reg b_asleep_reg;
reg [3:0] ss_step_reg;
reg [15:0] ss_cnt_reg;
reg [15:0] ss_limit;
// Base soft-start step length, cut to the counter width on purpose.
wire [31:0] ss_base_wide = `BCC_SS_BASE_CYC;
reg uv_prev_reg;
wire [6:0] ramp_level;
wire [1:0] b_src = b_ctl2_reg[12:11];
wire b_hwc_on;
wire b_dvs_on;
wire [2:0] on_slot = b_on_reg[15:13];
wire [2:0] slp_slot = b_slp_reg[15:13];
wire hw_en_assigned = (on_slot == 3'h6) || (on_slot == 3'h7);
wire hw_en_level = (on_slot == 3'h6) ? hw_enable_one : hw_enable_two;
wire [2:0] sleep_slot_num;
wire sleep_disables;
wire ramp_target_sel;
reg [6:0] target_code;
reg b_run;
reg [1:0] b_mode_now;
reg [15:0] rdata_next;

// Scaling source decode, shared by both low-voltage bucks.
function scale_active;
	input [1:0] src;
	input one;
	input two;
	begin
		case (src)
		2'h1: scale_active = 1'b1;
		2'h2: scale_active = one;
		2'h3: scale_active = two;
		default: scale_active = 1'b0;
		endcase
	end
endfunction

// Clamp a voltage code into the linear range of the low-voltage bucks.
function [6:0] clamp_code;
	input [6:0] code;
	begin
		if (code < `BCC_VMIN_CODE)
			clamp_code = `BCC_VMIN_CODE;
		else if (code > `BCC_VMAX_CODE)
			clamp_code = `BCC_VMAX_CODE;
		else
			clamp_code = code;
	end
endfunction

assign b_dvs_on = scale_active(b_dvs_reg[12:11], hw_scaling_input_one,
	hw_scaling_input_two); // RULE1
assign b_hwc_on = (b_src == 2'h1) ? hwctl_one :
	(b_src == 2'h2) ? hwctl_two :
	(b_src == 2'h3) ? (hwctl_one | hwctl_two) : 1'b0; // RULE11
// Sleep slot codes 1..5 mean slots 5 down to 1; others map to 5, 3, 1.
assign sleep_slot_num = (slp_slot == 3'h0) ? 3'h5 :
	(slp_slot == 3'h6) ? 3'h3 :
	(slp_slot == 3'h7) ? 3'h1 : (3'h6 - slp_slot); // RULE18
assign sleep_disables = (slp_slot != 3'h0) && (slp_slot != 3'h6) &&
	(slp_slot != 3'h7) && !hw_en_assigned; // RULE19
assign ramp_target_sel = b_hwc_on ? b_ctl2_reg[10] : b_asleep_reg;

// Target voltage: scaling, hardware choice, or sleep versus active.
always @*
begin
	if (b_dvs_on)
		target_code = clamp_code(b_dvs_reg[6:0]); // RULE2
	else if (ramp_target_sel)
		target_code = clamp_code(b_slp_reg[6:0]); // RULE12 RULE20
	else
		target_code = clamp_code(b_on_reg[6:0]); // RULE17
end

// Running state and mode from slots, hardware control and trips.
always @*
begin
	b_run = b_on_reg_state && !b_trip_reg;
	b_mode_now = b_asleep_reg ? b_slp_reg[9:8] : b_on_reg[9:8]; // RULE16
	if (b_asleep_reg && sleep_disables)
		b_run = 1'b0;
	if (b_hwc_on)
	begin
		b_mode_now = b_ctl2_reg[9:8]; // RULE13
		if (b_ctl2_reg[9:8] == `BCC_MODE_AUTO)
			b_run = 1'b0;
	end
end

// Output voltage slewer for the second buck.
bcc_ramp u_ramp
(
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.rate(b_ctl1_reg[15:14]),
	.target(target_code),
	.level_reg(ramp_level)
);

// Soft-start step length for the second buck.
always @*
begin
	case (b_ctl1_reg[5:4])
	2'h0: ss_limit = ss_base_wide[15:0];
	2'h1: ss_limit = {ss_base_wide[14:0], 1'b0};
	2'h2: ss_limit = {ss_base_wide[13:0], 2'b00};
	default: ss_limit = {ss_base_wide[12:0], 3'b000};
	endcase
end

// Register read mux; unmapped addresses read zero.
always @*
begin
	case (reg_addr)
	`BCC_OFF_A_DVS: rdata_next = a_dvs_reg;
	`BCC_OFF_B_CTL1: rdata_next = b_ctl1_reg;
	`BCC_OFF_B_CTL2: rdata_next = b_ctl2_reg;
	`BCC_OFF_B_ON: rdata_next = b_on_reg;
	`BCC_OFF_B_SLP: rdata_next = b_slp_reg;
	`BCC_OFF_B_DVS: rdata_next = b_dvs_reg;
	`BCC_OFF_C_CTL1: rdata_next = c_ctl1_reg; // RULE23
	`BCC_OFF_STATUS: rdata_next = {9'h000, ramp_level};
	`BCC_OFF_KEY: rdata_next = {15'h0000, unlock_reg};
	default: rdata_next = 16'h0000;
	endcase
end

// Register writes, key handling and OTP load.
always @(posedge sys_clk)
begin
	if (sys_rst)
	begin
		a_dvs_reg <= `BCC_RST_DVS;
		b_ctl1_reg <= `BCC_RST_CTL1; // RULE5
		b_ctl2_reg <= `BCC_RST_CTL2;
		b_on_reg <= `BCC_RST_ON;
		b_slp_reg <= `BCC_RST_SLP;
		b_dvs_reg <= `BCC_RST_DVS;
		c_ctl1_reg <= `BCC_RST_C1; // RULE21
		unlock_reg <= 1'b0;
		reg_rdata <= 16'h0000;
	end
	else
	begin
		reg_rdata <= reg_read ? rdata_next : 16'h0000;
		if (otp_load)
			b_on_reg[6:2] <= otp_active_voltage; // RULE17
		if (reg_write)
		begin
			case (reg_addr)
			`BCC_OFF_A_DVS: a_dvs_reg <= reg_wdata & `BCC_MASK_DVS;
			`BCC_OFF_B_CTL1: b_ctl1_reg <= reg_wdata & `BCC_MASK_CTL1;
			`BCC_OFF_B_CTL2: b_ctl2_reg <= reg_wdata & `BCC_MASK_CTL2;
			`BCC_OFF_B_ON: b_on_reg <= reg_wdata & `BCC_MASK_ON;
			`BCC_OFF_B_SLP: b_slp_reg <= reg_wdata & `BCC_MASK_SLP;
			`BCC_OFF_B_DVS: b_dvs_reg <= reg_wdata & `BCC_MASK_DVS;
			`BCC_OFF_C_CTL1:
			begin
				c_ctl1_reg[12] <= reg_wdata[12];
				c_ctl1_reg[7] <= reg_wdata[7];
				c_ctl1_reg[5:4] <= reg_wdata[5:4]; // RULE21
				c_ctl1_reg[1:0] <= reg_wdata[1:0];
				// Key-protected limit bits take a write only while unlocked.
				if (unlock_reg)
					c_ctl1_reg[3:2] <= reg_wdata[3:2]; // RULE22 RULE23
			end
			`BCC_OFF_KEY: unlock_reg <= (reg_wdata == `BCC_KEY_VALUE);
			default: unlock_reg <= unlock_reg;
			endcase
		end
	end
end

// Sequencing, soft start, undervoltage response and pin outputs.
always @(posedge sys_clk)
begin
	if (sys_rst)
	begin
		b_on_reg_state <= 1'b0;
		b_asleep_reg <= 1'b0;
		b_trip_reg <= 1'b0;
		ss_step_reg <= 4'h0;
		ss_cnt_reg <= 16'h0000;
		uv_prev_reg <= 1'b0;
		buck_b_enable <= 1'b0;
		buck_b_mode <= `BCC_MODE_AUTO;
		buck_b_voltage <= 7'h00;
		buck_b_clk_invert <= 1'b1;
		buck_b_freq <= 2'h0;
		buck_b_discharge <= 1'b1;
		buck_b_current_step <= 4'h0;
		buck_b_hc_enable <= 1'b0;
		buck_b_hc_threshold <= 3'h0;
		buck_b_undervolt_irq <= 1'b0;
		system_reset_req <= 1'b0;
		buck_a_scaling_active <= 1'b0;
		buck_c_current_limit <= 2'h1;
		buck_c_discharge <= 1'b1;
		buck_c_clk_invert <= 1'b0;
	end
	else
	begin
		uv_prev_reg <= buck_b_undervolt;
		// Power-up in the chosen slot, or follow a hardware enable.
		if (hw_en_assigned)
			b_on_reg_state <= hw_en_level; // RULE15
		else if (on_slot == 3'h0)
			b_on_reg_state <= 1'b0;
		else if (!sleep_request && power_on_timeslot == on_slot)
			b_on_reg_state <= 1'b1;
		if (!sleep_request)
			b_asleep_reg <= 1'b0;
		else if (sleep_timeslot == sleep_slot_num)
			b_asleep_reg <= 1'b1; // RULE18
		// A slot set to never releases a trip; a new trip in the same
		// cycle must still win, so the clear comes first.
		if (on_slot == 3'h0)
			b_trip_reg <= 1'b0;
		buck_b_undervolt_irq <= buck_b_undervolt & ~uv_prev_reg; // RULE10
		// Undervolt rising edge: the event always, then the chosen action.
		if (buck_b_undervolt && !uv_prev_reg)
		begin
			if (b_ctl2_reg[15:14] == 2'h1)
				b_trip_reg <= 1'b1; // RULE9
			system_reset_req <= (b_ctl2_reg[15:14] == 2'h2); // RULE9
		end
		else
			system_reset_req <= 1'b0;
		// Eight current-limit steps after each enable.
		if (!b_run)
		begin
			ss_step_reg <= 4'h0;
			ss_cnt_reg <= 16'h0000;
		end
		else if (ss_step_reg < `BCC_B_SS_STEPS)
		begin
			if (ss_cnt_reg + 16'h0001 >= ss_limit)
			begin
				ss_cnt_reg <= 16'h0000;
				ss_step_reg <= ss_step_reg + 4'h1; // RULE8
			end
			else
				ss_cnt_reg <= ss_cnt_reg + 16'h0001;
		end
		buck_b_current_step <= ss_step_reg;
		buck_b_enable <= b_run;
		buck_b_mode <= b_mode_now;
		buck_b_voltage <= ramp_level; // RULE2 RULE4
		buck_b_clk_invert <= b_ctl1_reg[12]; // RULE5
		buck_b_freq <= b_ctl1_reg[9:8]; // RULE6
		buck_b_discharge <= !b_run && !b_ctl1_reg[7]; // RULE7
		buck_b_hc_enable <= b_ctl2_reg[0]; // RULE14
		buck_b_hc_threshold <= b_ctl2_reg[6:4]; // RULE14
		buck_a_scaling_active <= scale_active(a_dvs_reg[12:11],
			hw_scaling_input_one, hw_scaling_input_two); // RULE1
		// Third buck: its enable lives elsewhere, so discharge follows float.
		buck_c_current_limit <= c_ctl1_reg[3:2]; // RULE22
		buck_c_discharge <= !c_ctl1_reg[7]; // RULE7
		buck_c_clk_invert <= c_ctl1_reg[12]; // RULE5
	end
end
endmodule
`default_nettype wire

// [tb_top.sv]
/*
 Bench for bcc_top: host model, read notes in a queue, checker bind.
 Assumes bcc_top, bcc_host and bcc_monitor are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.vh"
`define CHK(g, e) chk(g, e)
module tb_top;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hw_scaling_input_one = 1'b0;
	logic hwctl_one = 1'b0;
	logic hw_enable_one = 1'b0;
	logic buck_b_undervolt = 1'b0;
	logic sleep_request = 1'b0;
	logic otp_load = 1'b0;
	logic [2:0] sleep_timeslot = 3'h0;
	logic [4:0] otp_active_voltage = 5'h00;
	logic rd_seen = 1'b0;
	logic [15:0] d;
	logic [15:0] q[$];
	logic [15:0] offs[7] = '{`BCC_OFF_A_DVS, `BCC_OFF_B_CTL1,
		`BCC_OFF_B_CTL2, `BCC_OFF_B_ON, `BCC_OFF_B_SLP, `BCC_OFF_B_DVS,
		`BCC_OFF_C_CTL1};
	logic [15:0] rsts[7] = '{`BCC_RST_DVS, `BCC_RST_CTL1, `BCC_RST_CTL2,
		`BCC_RST_ON, `BCC_RST_SLP, `BCC_RST_DVS, `BCC_RST_C1};
	logic [15:0] msks[6] = '{`BCC_MASK_DVS, `BCC_MASK_CTL1,
		`BCC_MASK_CTL2, `BCC_MASK_ON, `BCC_MASK_SLP, `BCC_MASK_DVS};
	wire logic [15:0] reg_addr, reg_wdata, reg_rdata;
	wire logic reg_write, reg_read, buck_b_enable, buck_b_clk_invert;
	wire logic buck_b_hc_enable, buck_b_undervolt_irq, system_reset_req;
	wire logic buck_c_clk_invert, buck_b_discharge, buck_c_discharge;
	wire logic buck_a_scaling_active;
	wire logic [1:0] buck_b_mode, buck_b_freq, buck_c_current_limit;
	wire logic [2:0] buck_b_hc_threshold;
	wire logic [3:0] buck_b_current_step;
	wire logic [6:0] buck_b_voltage;
	int errors = 0, comparisons = 0, cyc = 0, nirq = 0, nsr = 0;
	int i, ni, ns;
	bcc_top uut
	(
		.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .hw_scaling_input_one, .hw_scaling_input_two(1'b0),
		.hwctl_one, .hwctl_two(1'b0), .hw_enable_one, .hw_enable_two(1'b0),
		.power_on_timeslot(3'h1), .sleep_timeslot,
		.sleep_request, .buck_b_undervolt, .otp_load,
		.otp_active_voltage, .buck_b_enable, .buck_b_mode,
		.buck_b_voltage, .buck_b_clk_invert, .buck_b_freq,
		.buck_b_discharge, .buck_b_current_step, .buck_b_hc_enable,
		.buck_b_hc_threshold, .buck_b_undervolt_irq, .system_reset_req,
		.buck_a_scaling_active, .buck_c_current_limit,
		.buck_c_discharge, .buck_c_clk_invert
	);
	bcc_host host
	(
		.sys_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read
	);
	// A 40 ns clock.
	initial
	begin
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		host.acc(1'b1, a, v);
	endtask
	// The expected word is noted before the strobe goes out.
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		q.push_back(e);
		host.acc(1'b0, a, 16'h0000);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic tend(input string n);
		$display("test %s done", n);
	endtask
	task end_of_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Read data meet the oldest note; events are counted; hang guard.
	always @(posedge sys_clk)
	begin
		if (rd_seen)
			`CHK(reg_rdata, q.pop_front());
		rd_seen <= reg_read;
		nirq <= nirq + buck_b_undervolt_irq;
		nsr <= nsr + system_reset_req;
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			errors++;
			end_of_test;
		end
	end
	// Main sequence; timeslot 1 is always current.
	initial
	begin
		i = $urandom(1181);
		wt(20);
		sys_rst <= 1'b0;
		wt(1);
		for (i = 0; i < 7; i++)
			rd(offs[i], rsts[i]);
		`CHK(buck_b_clk_invert, 1'b1);
		`CHK(buck_c_clk_invert, 1'b0);
		`CHK(buck_b_discharge, 1'b1);
		`CHK(buck_c_discharge, 1'b1);
		tend("reset");
		for (i = 0; i < 6; i++)
		begin
			d = 16'($urandom);
			if (i == 1)
				d[9:8] = 2'b01;
			wr(offs[i], d);
			rd(offs[i], d & msks[i]);
		end
		wr(16'h4080, 16'hffff);
		rd(16'h4080, 16'h0000);
		wr(`BCC_OFF_C_CTL1, 16'h00ac);
		rd(`BCC_OFF_C_CTL1, 16'h00a4);
		wr(`BCC_OFF_KEY, `BCC_KEY_VALUE);
		wr(`BCC_OFF_C_CTL1, 16'h00ac);
		rd(`BCC_OFF_C_CTL1, 16'h00ac);
		`CHK(buck_c_current_limit, 2'b11);
		`CHK(buck_c_discharge, 1'b0);
		tend("registers");
		wr(`BCC_OFF_B_DVS, 16'h0000);
		wr(`BCC_OFF_B_CTL1, 16'hc180);
		wr(`BCC_OFF_B_CTL2, 16'h0a51);
		hwctl_one <= 1'b1;
		wt(3);
		`CHK(buck_b_freq, 2'b01);
		`CHK(buck_b_clk_invert, 1'b0);
		`CHK(buck_b_hc_enable, 1'b1);
		`CHK(buck_b_hc_threshold, 3'h5);
		`CHK(buck_b_mode, 2'b10);
		hwctl_one <= 1'b0;
		wr(`BCC_OFF_B_ON, 16'h207f);
		wt(4);
		`CHK(buck_b_enable, 1'b1);
		`CHK(buck_b_mode, 2'b00);
		`CHK(buck_b_voltage, 7'h68);
		wr(`BCC_OFF_B_DVS, 16'h1030);
		wr(`BCC_OFF_A_DVS, 16'h1000);
		hw_scaling_input_one <= 1'b1;
		wt(4);
		`CHK(buck_b_voltage, 7'h30);
		`CHK(buck_a_scaling_active, 1'b1);
		wr(`BCC_OFF_B_CTL1, 16'h8180);
		wr(`BCC_OFF_B_ON, 16'h2032);
		hw_scaling_input_one <= 1'b0;
		wt(150);
		`CHK(buck_a_scaling_active, 1'b0);
		`CHK(buck_b_voltage == 7'h32, 1'b0);
		wt(300);
		`CHK(buck_b_voltage, 7'h32);
		wr(`BCC_OFF_B_ON, 16'hc032);
		hw_enable_one <= 1'b1;
		wt(4);
		`CHK(buck_b_enable, 1'b1);
		hw_enable_one <= 1'b0;
		wt(4);
		`CHK(buck_b_enable, 1'b0);
		tend("outputs");
		wr(`BCC_OFF_B_CTL1, 16'h8100);
		wr(`BCC_OFF_B_ON, 16'h2032);
		wt(900);
		`CHK(buck_b_current_step, 4'h1);
		for (i = 0; i < 3; i++)
		begin
			wr(`BCC_OFF_B_CTL2, 16'(i) << 14);
			ni = nirq;
			ns = nsr;
			buck_b_undervolt <= 1'b1;
			wt(3);
			buck_b_undervolt <= 1'b0;
			wt(2);
			`CHK(16'(nirq - ni), 16'h0001);
			`CHK(16'(nsr - ns), 16'(i == 2));
			`CHK(buck_b_enable, i != 1);
			`CHK(buck_b_discharge, i == 1);
			if (i == 1)
			begin
				wr(`BCC_OFF_B_ON, 16'h0000);
				wr(`BCC_OFF_B_ON, 16'h2032);
				wt(3);
			end
		end
		tend("undervolt");
		wr(`BCC_OFF_B_SLP, 16'hc340);
		sleep_request <= 1'b1;
		sleep_timeslot <= 3'h3;
		wt(4);
		`CHK(buck_b_mode, `BCC_MODE_HYST);
		`CHK(buck_b_enable, 1'b1);
		wr(`BCC_OFF_B_SLP, 16'h2340);
		sleep_timeslot <= 3'h5;
		wt(4);
		`CHK(buck_b_enable, 1'b0);
		wr(`BCC_OFF_B_ON, 16'hc032);
		hw_enable_one <= 1'b1;
		wt(4);
		`CHK(buck_b_enable, 1'b1);
		sleep_request <= 1'b0;
		otp_load <= 1'b1;
		otp_active_voltage <= 5'h15;
		wt(1);
		otp_load <= 1'b0;
		rd(`BCC_OFF_B_ON, 16'hc056);
		tend("sleep");
		wt(2);
		end_of_test;
	end
endmodule
bind bcc_top bcc_monitor mon
(
	.sys_clk, .sys_rst, .reg_addr, .reg_read, .reg_rdata,
	.buck_b_undervolt, .buck_b_undervolt_irq, .system_reset_req,
	.buck_b_current_step, .buck_b_voltage
);
`default_nettype wire
